/* File: hdl/drive_fault_alarm_manager.sv */
// Fault, alarm and error class manager for a motor drive
module drive_fault_alarm_manager #(
  parameter int FLASH_HALF = fault_alarm_pkg::FLASH_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [31:0] rdata,
  input wire logic [7:0] faultDet,
  input wire logic [7:0] minorDet,
  input wire logic [7:0] alarmDet,
  input wire logic cfgConflict,
  input wire logic [3:0] tuneErrDet,
  input wire logic tuneDone,
  input wire logic rampDone,
  output logic [7:0] displayCode,
  output logic alarmLamp,
  output logic [2:0] contactOut,
  output logic driveEnable,
  output logic rampStop,
  output logic tuneActive,
  output logic irq
);
  typedef enum logic [1:0] {ST_STOP, ST_RUN, ST_RAMP} state_t;
  function automatic logic [2:0] firstIdx(input logic [7:0] v);
    firstIdx = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (v[i])
        firstIdx = i[2:0];
  endfunction
  fault_alarm_pkg::ctrl_t ctrl_q;
  logic [23:0] contactSel_q;
  logic [4:0] irqMask_q;
  fault_alarm_pkg::cond_t irqStat_q, irqStat_d, condNow, condPrev_q;
  logic [7:0] faultLatch_q, minor_q, alarm_q;
  logic [3:0] tuneErr_q;
  logic opErr_q;
  state_t state_q, state_d;
  logic [31:0] flashCnt_q;
  logic flashPh_q;
  logic faultAny, minorAny, alarmAny, tuneErrAny, newTuneErr;
  logic ctrlWr, faultRst, tuneStart, runOk;
  assign ctrlWr = wrStb && (addr == fault_alarm_pkg::OFF_CTRL);
  assign faultRst = ctrlWr && wdata[fault_alarm_pkg::CTRL_RESET];
  assign tuneStart = ctrlWr && wdata[fault_alarm_pkg::CTRL_TUNE];
  assign faultAny = |faultLatch_q;
  assign minorAny = |minor_q;
  assign alarmAny = |alarm_q;
  assign tuneErrAny = |tuneErr_q;
  assign newTuneErr = tuneActive && (|tuneErrDet);
  // ==========================================
  // Register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= '0;
      contactSel_q <= fault_alarm_pkg::CONTACT_RST;
      irqMask_q <= fault_alarm_pkg::MASK_RST;
    end else if (wrStb) begin
      if (addr == fault_alarm_pkg::OFF_CTRL) begin
        ctrl_q.runReq <= wdata[fault_alarm_pkg::CTRL_RUN];
        ctrl_q.stopSel <= wdata[fault_alarm_pkg::CTRL_STOP_LSB +: 2];
      end else if (addr == fault_alarm_pkg::OFF_CONTACT) begin
        contactSel_q <= wdata[23:0];
      end else if (addr == fault_alarm_pkg::OFF_IRQ_MASK) begin
        irqMask_q <= wdata[4:0];
      end
    end
  end
  // ==========================================
  // Condition capture
  always_ff @(posedge clk) begin
    if (rst) begin
      faultLatch_q <= 8'h00;
      minor_q <= 8'h00;
      alarm_q <= 8'h00;
      opErr_q <= 1'b0;
    end else begin
      // latch until reset; new detection beats the reset
      faultLatch_q <= faultDet | (faultRst ? 8'h00 : faultLatch_q);
      minor_q <= minorDet;
      alarm_q <= alarmDet;
      opErr_q <= cfgConflict;
    end
  end
  // ==========================================
  // Auto-tuning
  always_ff @(posedge clk) begin
    if (rst) begin
      tuneActive <= 1'b0;
      tuneErr_q <= 4'h0;
    end else begin
      // tuning errors cleared only by a fresh start
      if (tuneStart) begin
        tuneErr_q <= 4'h0;
        tuneActive <= !faultAny && !opErr_q;
      end else begin
        // errors only raised while tuning runs
        if (tuneActive)
          tuneErr_q <= tuneErr_q | tuneErrDet;
        if (tuneDone || newTuneErr || faultAny)
          tuneActive <= 1'b0;
      end
    end
  end
  // ==========================================
  // Drive output sequencing
  // run permission
  assign runOk = (ctrl_q.runReq || tuneActive) && !faultAny &&
                 !opErr_q && !tuneErrAny && !newTuneErr;
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_STOP: begin
        if (runOk && faultDet == 8'h00)
          state_d = ST_RUN;
      end
      ST_RUN: begin
        if (|faultDet || faultAny) begin
          if (ctrl_q.stopSel == fault_alarm_pkg::STOP_RAMP)
            state_d = ST_RAMP;
          else
            state_d = ST_STOP;
        end else if (!runOk) begin
          // minor faults never reach this term
          state_d = ST_STOP;
        end
      end
      ST_RAMP: begin
        // tuning error coasts even mid ramp
        if (rampDone || newTuneErr)
          state_d = ST_STOP;
      end
      default: state_d = ST_STOP;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_STOP;
      driveEnable <= 1'b0;
      rampStop <= 1'b0;
    end else begin
      state_q <= state_d;
      driveEnable <= (state_d != ST_STOP);
      rampStop <= (state_d == ST_RAMP);
    end
  end
  // ==========================================
  // Operator display and lamp
  // Half period is long; parameter lets simulation shorten it
  always_ff @(posedge clk) begin
    if (rst) begin
      flashCnt_q <= 32'h0;
      flashPh_q <= 1'b0;
    end else if (flashCnt_q >= 32'(FLASH_HALF - 1)) begin
      flashCnt_q <= 32'h0;
      flashPh_q <= !flashPh_q;
    end else begin
      flashCnt_q <= flashCnt_q + 32'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      displayCode <= fault_alarm_pkg::CODE_NONE;
      alarmLamp <= 1'b0;
    end else begin
      if (faultAny) begin
        displayCode <= fault_alarm_pkg::CODE_FAULT +
                       {5'h0, firstIdx(faultLatch_q)};
      end else if (opErr_q) begin
        displayCode <= fault_alarm_pkg::CODE_OPERR;
      end else if (tuneErrAny) begin
        displayCode <= fault_alarm_pkg::CODE_TUNE +
                       {5'h0, firstIdx({4'h0, tuneErr_q})};
      end else if (minorAny) begin
        displayCode <= fault_alarm_pkg::CODE_MINOR +
                       {5'h0, firstIdx(minor_q)};
      end else if (alarmAny) begin
        displayCode <= fault_alarm_pkg::CODE_ALARM +
                       {5'h0, firstIdx(alarm_q)};
      end else begin
        displayCode <= fault_alarm_pkg::CODE_NONE;
      end
      if (faultAny)
        alarmLamp <= 1'b1;
      else if (minorAny || alarmAny)
        alarmLamp <= flashPh_q;
      else
        alarmLamp <= 1'b0;
    end
  end
  // ==========================================
  // Contact outputs
  // errors have no path here
  always_ff @(posedge clk) begin
    if (rst) begin
      contactOut <= 3'h0;
    end else begin
      for (int i = 0; i < fault_alarm_pkg::NUM_CONTACT; i++) begin
        if (contactSel_q[i*8 +: 8] == fault_alarm_pkg::FUNC_FAULT)
          contactOut[i] <= faultAny;
        else if (contactSel_q[i*8 +: 8] == fault_alarm_pkg::FUNC_MINOR)
          contactOut[i] <= minorAny;
        else
          contactOut[i] <= 1'b0;
      end
    end
  end
  // ==========================================
  // Interrupts and read port
  assign condNow = '{faultAny, minorAny, alarmAny, opErr_q, tuneErrAny};
  always_comb begin
    irqStat_d = irqStat_q;
    if (rdStb && addr == fault_alarm_pkg::OFF_IRQ_STAT)
      irqStat_d = '0;
    // Set after clear so a coincident event survives
    irqStat_d = irqStat_d | (condNow & ~condPrev_q);
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      condPrev_q <= '0;
      irqStat_q <= '0;
      irq <= 1'b0;
      rdata <= 32'h0;
    end else begin
      condPrev_q <= condNow;
      irqStat_q <= irqStat_d;
      irq <= |(irqStat_d & irqMask_q);
      if (!rdStb) begin
        rdata <= 32'h0;
      end else if (addr == fault_alarm_pkg::OFF_CTRL) begin
        rdata <= {29'h0, ctrl_q};
      end else if (addr == fault_alarm_pkg::OFF_CONTACT) begin
        rdata <= {8'h0, contactSel_q};
      end else if (addr == fault_alarm_pkg::OFF_STATUS) begin
        rdata <= {16'h0, displayCode, tuneActive, rampStop,
                  driveEnable, condNow};
      end else if (addr == fault_alarm_pkg::OFF_IRQ_STAT) begin
        rdata <= {27'h0, irqStat_q};
      end else if (addr == fault_alarm_pkg::OFF_IRQ_MASK) begin
        rdata <= {27'h0, irqMask_q};
      end else if (addr == fault_alarm_pkg::OFF_DETAIL) begin
        rdata <= {4'h0, tuneErr_q, alarm_q, minor_q, faultLatch_q};
      end else begin
        rdata <= 32'h0;
      end
    end
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic contactWr;
  assign contactWr = wrStb && addr == fault_alarm_pkg::OFF_CONTACT;
  property p_fault_lamp;
    faultAny |=> alarmLamp && displayCode[7:4] == 4'h1;
  endproperty
  a_fault_lamp: assert property (p_fault_lamp)
    else $error("fault lamp or code wrong");
  property p_fault_coast;
    (|faultDet && state_q == ST_RUN &&
     ctrl_q.stopSel == fault_alarm_pkg::STOP_COAST) |=> !driveEnable;
  endproperty
  a_fault_coast: assert property (p_fault_coast)
    else $error("fault did not cut drive");
  property p_fault_ramp;
    (|faultDet && state_q == ST_RUN &&
     ctrl_q.stopSel == fault_alarm_pkg::STOP_RAMP)
      |=> rampStop && driveEnable;
  endproperty
  a_fault_ramp: assert property (p_fault_ramp)
    else $error("ramp stop not taken");
  property p_contact_fault;
    (contactSel_q[15:8] == fault_alarm_pkg::FUNC_FAULT && faultAny &&
     !contactWr) |=> contactOut[1];
  endproperty
  a_contact_fault: assert property (p_contact_fault)
    else $error("fault contact open");
  property p_fault_block;
    // A reset write in this cycle may free the drive two edges on
    (faultAny && !faultRst && state_q == ST_STOP) |=> !driveEnable [*2];
  endproperty
  a_fault_block: assert property (p_fault_block)
    else $error("ran with latched fault");
  property p_minor_flash;
    (!faultAny && minorAny) |=> alarmLamp == $past(flashPh_q);
  endproperty
  a_minor_flash: assert property (p_minor_flash)
    else $error("minor lamp not flashing");
  property p_minor_contact;
    (contactSel_q[23:16] == fault_alarm_pkg::FUNC_MINOR && !minorAny &&
     !contactWr) |=> !contactOut[2];
  endproperty
  a_minor_contact: assert property (p_minor_contact)
    else $error("minor contact closed on alarm");
  property p_operr_block;
    (opErr_q && state_q != ST_RAMP && faultDet == 8'h00) |=> !driveEnable;
  endproperty
  a_operr_block: assert property (p_operr_block)
    else $error("drive on during operation error");
  property p_tune_only;
    (!tuneActive && !tuneStart) |=> $stable(tuneErr_q);
  endproperty
  a_tune_only: assert property (p_tune_only)
    else $error("tuning error outside tuning");
  property p_tune_coast;
    newTuneErr |=> !driveEnable && !tuneActive;
  endproperty
  a_tune_coast: assert property (p_tune_coast)
    else $error("tuning error kept drive");
  c_fault_ramp: cover property (state_q == ST_RAMP ##1 state_q == ST_STOP);
  c_minor_run: cover property (minorAny && driveEnable);
  c_tune_err: cover property (newTuneErr);
endmodule

/* File: inc/fault_alarm_pkg.sv */
// Package: constants and types for the drive fault and alarm manager
package fault_alarm_pkg;
  // ==========================================
  // Sizes
  localparam int NUM_DET = 8;
  localparam int NUM_TUNE = 4;
  localparam int NUM_CONTACT = 3;
  // ==========================================
  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CONTACT = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_DETAIL = 8'h14;
  // Control bit positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_STOP_LSB = 1;
  localparam int CTRL_TUNE = 3;
  localparam int CTRL_RESET = 4;
  // ==========================================
  // Reset values
  localparam logic [23:0] CONTACT_RST = 24'h000000;
  localparam logic [4:0] MASK_RST = 5'h00;
  // ==========================================
  // Contact output function codes
  localparam logic [7:0] FUNC_FAULT = 8'h0e;
  localparam logic [7:0] FUNC_MINOR = 8'h10;
  // Operator display codes
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_FAULT = 8'h10;
  localparam logic [7:0] CODE_MINOR = 8'h20;
  localparam logic [7:0] CODE_ALARM = 8'h30;
  localparam logic [7:0] CODE_OPERR = 8'h40;
  localparam logic [7:0] CODE_TUNE = 8'h50;
  // Stop method
  localparam logic [1:0] STOP_COAST = 2'h0;
  localparam logic [1:0] STOP_RAMP = 2'h1;
  // ==========================================
  // Timing
  localparam int CLK_KHZ = 100000;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CLK_KHZ;
  // ==========================================
  // Types
  typedef struct packed {
    logic [1:0] stopSel;
    logic runReq;
  } ctrl_t;
  typedef struct packed {
    logic fault;
    logic minor;
    logic alarm;
    logic opErr;
    logic tune;
  } cond_t;
endpackage

/* File: bench/power_stage_model.sv */
// Power stage model: answers ramp stop requests after a delay
module power_stage_model #(
  parameter int RAMP_CYC = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rampStop,
  output logic rampDone
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Deceleration timer
  int cnt_q;
  // ramp stop answered
  // Pulse only, so the design must latch the end of ramp itself
  always_ff @(posedge clk) begin
    if (rst || !rampStop) begin
      cnt_q <= 0;
      rampDone <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 1;
      rampDone <= (cnt_q == RAMP_CYC);
    end
  end
endmodule

/* File: bench/drive_fault_alarm_manager_tb.sv */
// Self-checking bench for the fault and alarm manager
module drive_fault_alarm_manager_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Signals
  localparam int FH = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic [31:0] rdata;
  logic [7:0] faultDet = 8'h00;
  logic [7:0] minorDet = 8'h00;
  logic [7:0] alarmDet = 8'h00;
  logic cfgConflict = 1'b0;
  logic [3:0] tuneErrDet = 4'h0;
  logic tuneDone = 1'b0;
  logic rampDone;
  logic [7:0] displayCode;
  logic alarmLamp;
  logic [2:0] contactOut;
  logic driveEnable;
  logic rampStop;
  logic tuneActive;
  logic irq;
  logic [31:0] rv;
  int errTotal = 0;
  int samplesChecked = 0;
  int ones;
  always #5 clk = ~clk;
  drive_fault_alarm_manager #(.FLASH_HALF(FH)) drive_fault_alarm_manager_inst (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wrStb(wrStb),
    .rdStb(rdStb), .rdata(rdata), .faultDet(faultDet),
    .minorDet(minorDet), .alarmDet(alarmDet), .cfgConflict(cfgConflict),
    .tuneErrDet(tuneErrDet), .tuneDone(tuneDone), .rampDone(rampDone),
    .displayCode(displayCode), .alarmLamp(alarmLamp),
    .contactOut(contactOut), .driveEnable(driveEnable),
    .rampStop(rampStop), .tuneActive(tuneActive), .irq(irq));
  power_stage_model power_stage_model_inst (
    .clk(clk), .rst(rst), .rampStop(rampStop), .rampDone(rampDone));
  // ==========================================
  // Helpers
  task automatic ck(input string nm, input logic [31:0] e,
                    input logic [31:0] g);
    samplesChecked++;
    if (g !== e) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    @(negedge clk);
    rv = rdata;
  endtask
  task automatic giveVerdict();
    if (errTotal == 0 && samplesChecked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs();
    rd(fault_alarm_pkg::OFF_CONTACT); ck("contactRst", 32'h0, rv);
    rd(fault_alarm_pkg::OFF_IRQ_MASK); ck("maskRst", 32'h0, rv);
    wr(8'h20, 32'hffffffff);
    rd(8'h20); ck("unmapped", 32'h0, rv);
    wr(fault_alarm_pkg::OFF_STATUS, 32'hffffffff);
    rd(fault_alarm_pkg::OFF_STATUS); ck("statusRo", 32'h0, rv);
    wr(fault_alarm_pkg::OFF_CONTACT, {8'h00, fault_alarm_pkg::FUNC_MINOR,
       fault_alarm_pkg::FUNC_FAULT, 8'h00});
    wr(fault_alarm_pkg::OFF_IRQ_MASK, 32'h1f);
    rd(fault_alarm_pkg::OFF_IRQ_MASK); ck("mask", 32'h1f, rv);
    wr(fault_alarm_pkg::OFF_CTRL, 32'h1);
    wt(3); ck("runEn", 1, driveEnable);
  endtask
  task automatic t_fault();
    @(posedge clk) faultDet <= 8'h04;
    @(posedge clk) faultDet <= 8'h00;
    wt(3);
    ck("coast", 0, driveEnable);
    ck("faultCode", 8'h12, displayCode);
    ck("lampOn", 1, alarmLamp);
    ck("faultContact", 3'b010, contactOut);
    ck("irqFault", 1, irq);
    rd(fault_alarm_pkg::OFF_IRQ_STAT); ck("irqStat", 32'h10, rv);
    wt(1); ck("irqClr", 0, irq);
    wt(3 * FH);
    ck("staysOff", 0, driveEnable);
    ck("lampSteady", 1, alarmLamp);
    wr(fault_alarm_pkg::OFF_CTRL, 32'h11);
    wt(4);
    ck("resumed", 1, driveEnable);
    ck("lampOff", 0, alarmLamp);
    ck("codeOff", 8'h00, displayCode);
  endtask
  task automatic t_ramp();
    wr(fault_alarm_pkg::OFF_CTRL, 32'h3);
    @(posedge clk) faultDet <= 8'h01;
    @(posedge clk) faultDet <= 8'h00;
    wt(1); ck("rampOn", 1, rampStop);
    wt(12);
    ck("rampEnd", 0, rampStop);
    ck("rampCut", 0, driveEnable);
    wr(fault_alarm_pkg::OFF_CTRL, 32'h11);
    wt(4); ck("rampReset", 1, driveEnable);
  endtask
  task automatic t_minor();
    @(posedge clk) minorDet <= 8'h02;
    wt(4);
    ck("minorCode", 8'h21, displayCode);
    ck("minorRun", 1, driveEnable);
    ck("minorContact", 3'b100, contactOut);
    ones = 0;
    for (int i = 0; i < 3 * FH; i++) begin
      wt(1);
      ones += alarmLamp;
    end
    ck("flash", 1, ones > 0 && ones < 3 * FH);
    @(posedge clk) begin
      minorDet <= 8'h00;
      alarmDet <= 8'h08;
    end
    wt(4);
    ck("alarmCode", 8'h33, displayCode);
    ck("alarmContact", 3'b000, contactOut);
    ck("alarmRun", 1, driveEnable);
    @(posedge clk) alarmDet <= 8'h00;
    wt(4);
    ck("selfClr", 8'h00, displayCode);
    ck("selfLamp", 0, alarmLamp);
  endtask
  task automatic t_operr();
    @(posedge clk) cfgConflict <= 1'b1;
    wt(4);
    ck("opCode", 8'h40, displayCode);
    ck("opContact", 3'b000, contactOut);
    ck("opBlock", 0, driveEnable);
    @(posedge clk) cfgConflict <= 1'b0;
    wt(4);
    ck("opClr", 8'h00, displayCode);
    ck("opRun", 1, driveEnable);
  endtask
  task automatic t_tune();
    @(posedge clk) tuneErrDet <= 4'h1;
    wt(4); ck("noTuneErr", 8'h00, displayCode);
    @(posedge clk) tuneErrDet <= 4'h0;
    wr(fault_alarm_pkg::OFF_CTRL, 32'h9);
    wt(3); ck("tuneOn", 1, tuneActive);
    @(posedge clk) tuneErrDet <= 4'h2;
    wt(4);
    ck("tuneCode", 8'h51, displayCode);
    ck("tuneContact", 3'b000, contactOut);
    ck("tuneCoast", 0, driveEnable);
    @(posedge clk) tuneErrDet <= 4'h0;
    wr(fault_alarm_pkg::OFF_CTRL, 32'h9);
    wt(3);
    ck("retune", 1, tuneActive);
    ck("retuneCode", 8'h00, displayCode);
    @(posedge clk) tuneDone <= 1'b1;
    @(posedge clk) tuneDone <= 1'b0;
    wt(3);
    ck("tuneEnd", 0, tuneActive);
    ck("tuneRun", 1, driveEnable);
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_fault();
    t_ramp();
    t_minor();
    t_operr();
    t_tune();
    giveVerdict();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    giveVerdict();
  end
endmodule
